// ===== core/sfs_regs.svh
// constants of the system fault supervisor: bus address, register map, timing
// assumes a 125 MHz core clock and a host that runs the two-wire bus
`ifndef SFS_REGS_SVH
`define SFS_REGS_SVH

// =====================================================================
// two-wire bus addresses
`define SFS_ADDR7 7'h6B
`define SFS_ADDR_WR 8'hD6
`define SFS_ADDR_RD 8'hD7

// =====================================================================
// register offsets, fields and reset values
`define SFS_REG_ID 8'h00
`define SFS_REG_INT 8'h03
`define SFS_REG_CTRL 8'h05
`define SFS_INT_PWRUP 0
`define SFS_INT_UVLO 4
`define SFS_INT_OVLO 5
`define SFS_INT_DIE_OVERTEMP_SHUTDOWN 6
`define SFS_CTRL_DEBEN 0
`define SFS_CTRL_RST 1'h0
`define SFS_CHIP_ID 8'h5A

// =====================================================================
// timing in nanoseconds and core clock period; bus pacing in core clocks per quarter bit
`define SFS_CLK_NS 8
`define SFS_UVLO_DEB_NS 8000000
`define SFS_OVLO_DEB_NS 100000
`define SFS_DIE_OVERTEMP_SHUTDOWN_DEB_NS 175000
`define SFS_PWRUP_TMO_NS 1000000
`define SFS_SCL_QDIV 32

`endif

// ===== core/sfs_pkg.sv
// types shared by both ends of the system fault supervisor
// assumes nothing beyond the constants header
package sfs_pkg;
  // =====================================================================
  // slave sequencer states
  typedef enum logic [2:0] {SL_IDLE, SL_ADDR, SL_WR, SL_ACK, SL_RD, SL_RACK} sfs_slv_e;
  // host sequencer states
  typedef enum logic [1:0] {HS_IDLE, HS_START, HS_BYTE, HS_STOP} sfs_host_e;
  // one bus byte
  typedef logic [7:0] sfs_byte_t;
endpackage

// ===== core/sfs_i2c_if.sv
// the two-wire bus between the host end and the device end
// assumes open-drain wires with pull-ups; an enable pulls the wire low
interface sfs_i2c_if;
  // =====================================================================
  // drives from each party
  logic host_scl_out;
  logic host_scl_oe;
  logic host_sda_out;
  logic host_sda_oe;
  logic dev_sda_out;
  logic dev_sda_oe;
  // resolved wire levels, high when nobody pulls
  logic scl;
  logic sda;
  assign scl = !(host_scl_oe && !host_scl_out);
  assign sda = !((host_sda_oe && !host_sda_out) || (dev_sda_oe && !dev_sda_out));
  // device listens to scl and sda, drives only sda
  modport dev (input scl, input sda, output dev_sda_out, output dev_sda_oe);
  modport host (input scl, input sda, output host_scl_out, output host_scl_oe,
    output host_sda_out, output host_sda_oe);
endinterface

// ===== core/sfs_device.sv
// device end: rail and die fault supervisor with its two-wire slave port
// assumes analog comparator levels arrive asynchronously on the inputs and
// that LINK_CLK_IN runs fast enough to oversample the bus clock
`include "sfs_regs.svh"

// What this block does
// - rail undervoltage held 8ms: shutdown, register reset
// - rail overvoltage: shutdown, debounce none or 100us
// - rail not up by timeout: powerup fault flag
// - die over 155C for 175us: shutdown, reset
// - shutdown holds until die cooled 15C
// - charger overheating turns off only charger
// - debounce timings apply in charge/buck mode
// - host powers io supply to service flag
// - slave answers at address 0x6B
// - one bit per clock, sda steady high
// - idle bus leaves both wires released
// - start and stop decoded while scl high
// - supply-loss reset returns registers to default
// - acknowledge each byte; master nacks last
module sfs_device
  import sfs_pkg::*;
#(
  parameter int UVLO_DEB_CYC = (`SFS_UVLO_DEB_NS + `SFS_CLK_NS - 1) / `SFS_CLK_NS,
  parameter int OVLO_DEB_CYC = (`SFS_OVLO_DEB_NS + `SFS_CLK_NS - 1) / `SFS_CLK_NS,
  parameter int DIE_OVERTEMP_SHUTDOWN_DEB_CYC = (`SFS_DIE_OVERTEMP_SHUTDOWN_DEB_NS + `SFS_CLK_NS - 1) / `SFS_CLK_NS,
  parameter int PWRUP_TMO_CYC = `SFS_PWRUP_TMO_NS / `SFS_CLK_NS
) (
  // core clock, reset, enable
  input wire logic CLOCK_IN,
  input wire logic RESET_N_IN,
  input wire logic CE_IN,
  // link clock that oversamples the bus
  input wire logic LINK_CLK_IN,
  // comparator levels
  input wire logic RAIL_UNDERVOLT_IN,
  input wire logic RAIL_OVERVOLT_IN,
  input wire logic RAIL_BELOW_VDD_IN,
  input wire logic RAIL_POWERED_IN,
  input wire logic SOURCE_VALID_IN,
  input wire logic DIE_OVERTEMP_IN,
  input wire logic DIE_COOLED_IN,
  input wire logic CHARGER_OVERTEMP_IN,
  input wire logic CHG_OR_BUCK_MODE_IN,
  // supervisor actions
  output logic SHUTDOWN_OUT,
  output logic REG_RESET_OUT,
  output logic DIE_OVERTEMP_SHUTDOWN_OUT,
  output logic POWERUP_FAULT_OUT,
  output logic POWERUP_CURRENT_EN_OUT,
  output logic CHARGER_OFF_OUT,
  // bus
  sfs_i2c_if.dev bus
);
  // =====================================================================
  // input synchronisers, core domain
  logic [8:0] in_meta_r; // first stage, read by second only
  logic [8:0] in_s_r; // usable levels
  logic [2:0] rc_sync_r; // read-clear toggle crossing
  logic [1:0] deb_sync_r; // overvoltage debounce enable crossing
  sfs_slv_e st_r; // bus phase
  sfs_byte_t sh_r; // shift register
  sfs_byte_t ptr_r; // register pointer
  logic [3:0] cnt_r; // bits moved in this byte
  logic rw_r; // read transfer
  logic first_r; // next written byte is the pointer
  logic drv_r; // pull sda low
  logic ctrl_r; // overvoltage debounce enable
  logic rc_tgl_r; // toggles on each flag register read
  wire uv_s = in_s_r[0];
  wire ov_s = in_s_r[1];
  wire svdd_s = in_s_r[2];
  wire pwrd_s = in_s_r[3];
  wire src_s = in_s_r[4];
  wire ot_s = in_s_r[5];
  wire cool_s = in_s_r[6];
  wire chgot_s = in_s_r[7];
  wire mode_s = in_s_r[8];
  wire deben_s = deb_sync_r[1];

  // sample all asynchronous levels through two flops
  always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      in_meta_r <= '0;
      in_s_r <= '0;
    end else if (CE_IN) begin
      in_meta_r <= {CHG_OR_BUCK_MODE_IN, CHARGER_OVERTEMP_IN, DIE_COOLED_IN, DIE_OVERTEMP_IN,
        SOURCE_VALID_IN, RAIL_POWERED_IN, RAIL_BELOW_VDD_IN, RAIL_OVERVOLT_IN, RAIL_UNDERVOLT_IN};
      in_s_r <= in_meta_r;
    end
  end

  // =====================================================================
  // fault debounce counters: 0 uvlo, 1 ovlo, 2 die temp, 3 powerup timeout
  logic die_overtemp_shutdown_r; // die overtemp shutdown latch
  logic pwf_r; // powerup fault latch
  logic [3:0] trip; // debounced fault levels
  logic [3:0] trip_d_r; // previous trip, for flag edges
  logic [3:0] flags_r; // sticky flags: pwrup, uvlo, ovlo, die_overtemp_shutdown
  wire [3:0] cond = {src_s && !pwrd_s && !pwf_r, ot_s, ov_s, uv_s};
  wire [19:0] lim [4];
  assign lim[0] = 20'(UVLO_DEB_CYC);
  assign lim[1] = deben_s ? 20'(OVLO_DEB_CYC) : 20'h0_0001;
  assign lim[2] = 20'(DIE_OVERTEMP_SHUTDOWN_DEB_CYC);
  assign lim[3] = 20'(PWRUP_TMO_CYC);

  genvar gi;
  for (gi = 0; gi < 4; gi++) begin : g_deb
    logic [19:0] cnt_r; // cycles the condition has held
    // outside charge/buck mode the rail and die faults act at once
    wire [19:0] lim_w = (mode_s || gi == 3) ? lim[gi] : 20'h0_0001;
    wire [19:0] cnt_nxt = !cond[gi] ? 20'h0_0000 :
      (cnt_r >= lim_w) ? lim_w : cnt_r + 20'h0_0001;
    assign trip[gi] = cond[gi] && (cnt_r >= lim_w);
    // count while the condition holds, restart when it drops
    always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) cnt_r <= 20'h0_0000;
      else if (CE_IN) cnt_r <= cnt_nxt;
    end
  end

  // =====================================================================
  // latches, flags and actions
  wire rc_pulse = rc_sync_r[2] ^ rc_sync_r[1]; // host read the flag register
  wire die_overtemp_shutdown_nxt = trip[2] ? 1'b1 : (cool_s && !ot_s) ? 1'b0 : die_overtemp_shutdown_r;
  wire pwf_nxt = trip[3] ? 1'b1 : (!src_s || pwrd_s) ? 1'b0 : pwf_r;
  wire shut_w = trip[0] || trip[1] || die_overtemp_shutdown_r;
  wire [3:0] rise = trip & ~trip_d_r;
  wire [3:0] set_w = {rise[2], rise[1], rise[0], rise[3]};
  // set beats a read clear in the same cycle; supply loss clears all
  wire [3:0] flags_nxt = svdd_s ? 4'h0 : (set_w | (rc_pulse ? 4'h0 : flags_r));

  // latches, flags and registered outputs
  always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      die_overtemp_shutdown_r <= 1'b0;
      pwf_r <= 1'b0;
      trip_d_r <= 4'h0;
      flags_r <= 4'h0;
      rc_sync_r <= 3'h0;
      deb_sync_r <= 2'h0;
      SHUTDOWN_OUT <= 1'b0;
      REG_RESET_OUT <= 1'b0;
      DIE_OVERTEMP_SHUTDOWN_OUT <= 1'b0;
      POWERUP_FAULT_OUT <= 1'b0;
      POWERUP_CURRENT_EN_OUT <= 1'b0;
      CHARGER_OFF_OUT <= 1'b0;
    end else if (CE_IN) begin
      die_overtemp_shutdown_r <= die_overtemp_shutdown_nxt;
      pwf_r <= pwf_nxt;
      trip_d_r <= trip;
      flags_r <= flags_nxt;
      rc_sync_r <= {rc_sync_r[1:0], rc_tgl_r};
      deb_sync_r <= {deb_sync_r[0], ctrl_r};
      SHUTDOWN_OUT <= shut_w;
      REG_RESET_OUT <= shut_w || svdd_s;
      DIE_OVERTEMP_SHUTDOWN_OUT <= die_overtemp_shutdown_r;
      POWERUP_FAULT_OUT <= pwf_r;
      POWERUP_CURRENT_EN_OUT <= src_s && !pwrd_s && !pwf_r;
      // charger overheat never reaches the shutdown path
      CHARGER_OFF_OUT <= chgot_s;
    end
  end

  // =====================================================================
  // link domain: bus sampling and register reset crossing
  logic [2:0] ln_meta_r; // first stage: scl, sda, reset
  logic [2:0] ln_s_r; // usable levels
  logic [3:0] fl_meta_r; // flag crossing, quasi-static bits
  logic [3:0] fl_s_r;
  logic scl_d_r; // previous scl level
  logic sda_d_r; // previous sda level
  wire scl_s = ln_s_r[0];
  wire sda_s = ln_s_r[1];
  wire lrst_s = ln_s_r[2];

  // two flops on every level entering the link domain
  always_ff @(posedge LINK_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      ln_meta_r <= 3'h3;
      ln_s_r <= 3'h3;
      fl_meta_r <= 4'h0;
      fl_s_r <= 4'h0;
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      ln_meta_r <= {REG_RESET_OUT, bus.sda, bus.scl};
      ln_s_r <= ln_meta_r;
      fl_meta_r <= flags_r;
      fl_s_r <= fl_meta_r;
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
    end
  end

  // =====================================================================
  // slave decode
  wire scl_rise = scl_s && !scl_d_r;
  wire scl_fall = !scl_s && scl_d_r;
  wire start_w = scl_s && scl_d_r && sda_d_r && !sda_s;
  wire stop_w = scl_s && scl_d_r && !sda_d_r && sda_s;
  wire addr_hit = sh_r[7:1] == `SFS_ADDR7;
  logic [7:0] int_byte; // flag register image
  always_comb begin
    int_byte = 8'h00;
    int_byte[`SFS_INT_PWRUP] = fl_s_r[0];
    int_byte[`SFS_INT_UVLO] = fl_s_r[1];
    int_byte[`SFS_INT_OVLO] = fl_s_r[2];
    int_byte[`SFS_INT_DIE_OVERTEMP_SHUTDOWN] = fl_s_r[3];
  end
  wire [7:0] ctrl_byte = {7'h00, ctrl_r} << `SFS_CTRL_DEBEN;
  wire [7:0] rd_w = (ptr_r == `SFS_REG_ID) ? `SFS_CHIP_ID :
    (ptr_r == `SFS_REG_INT) ? int_byte :
    (ptr_r == `SFS_REG_CTRL) ? ctrl_byte : 8'h00;

  // =====================================================================
  // slave sequencer
  assign bus.dev_sda_out = 1'b0;
  assign bus.dev_sda_oe = drv_r;

  // decode start, stop and each clock edge
  always_ff @(posedge LINK_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      st_r <= SL_IDLE;
      sh_r <= 8'h00;
      ptr_r <= 8'h00;
      cnt_r <= 4'h0;
      rw_r <= 1'b0;
      first_r <= 1'b0;
      drv_r <= 1'b0;
      ctrl_r <= `SFS_CTRL_RST;
      rc_tgl_r <= 1'b0;
    end else if (lrst_s) begin
      // fault or supply reset: defaults, no pending transfer
      st_r <= SL_IDLE;
      ptr_r <= 8'h00;
      drv_r <= 1'b0;
      ctrl_r <= `SFS_CTRL_RST;
    end else if (start_w) begin
      st_r <= SL_ADDR;
      cnt_r <= 4'h0;
      drv_r <= 1'b0;
    end else if (stop_w) begin
      st_r <= SL_IDLE;
      drv_r <= 1'b0;
    end else if (scl_rise) begin
      // sample on the rising edge, data is stable while scl high
      if (st_r == SL_ADDR || st_r == SL_WR) begin
        sh_r <= {sh_r[6:0], sda_s};
        cnt_r <= cnt_r + 4'h1;
      end else if (st_r == SL_RACK) begin
        rw_r <= !sda_s; // master ack keeps the read going
      end
    end else if (scl_fall) begin
      unique case (st_r)
        SL_IDLE: drv_r <= 1'b0;
        SL_ADDR: begin
          if (cnt_r == 4'h8) begin
            // foreign address: stay off the bus until the next start
            st_r <= addr_hit ? SL_ACK : SL_IDLE;
            drv_r <= addr_hit;
            rw_r <= sh_r[0];
            first_r <= !sh_r[0];
          end
        end
        SL_WR: begin
          if (cnt_r == 4'h8) begin
            st_r <= SL_ACK;
            drv_r <= 1'b1;
            first_r <= 1'b0;
            if (first_r) ptr_r <= sh_r;
            else ptr_r <= ptr_r + 8'h01;
            if (!first_r && ptr_r == `SFS_REG_CTRL) ctrl_r <= sh_r[`SFS_CTRL_DEBEN];
          end
        end
        SL_ACK, SL_RACK: begin
          cnt_r <= 4'h0;
          if (rw_r) begin
            st_r <= SL_RD;
            sh_r <= {rd_w[6:0], 1'b0};
            drv_r <= !rd_w[7];
            ptr_r <= ptr_r + 8'h01;
            if (ptr_r == `SFS_REG_INT) rc_tgl_r <= !rc_tgl_r;
          end else begin
            // write, or a read the master ended with a nack
            st_r <= (st_r == SL_RACK) ? SL_IDLE : SL_WR;
            drv_r <= 1'b0;
          end
        end
        SL_RD: begin
          cnt_r <= cnt_r + 4'h1;
          if (cnt_r == 4'h7) begin
            st_r <= SL_RACK;
            drv_r <= 1'b0;
          end else begin
            drv_r <= !sh_r[7];
            sh_r <= {sh_r[6:0], 1'b0};
          end
        end
      endcase
    end
  end
endmodule // sfs_device

// ===== core/sfs_host.sv
// host end: two-wire bus master that writes or reads one device register
// assumes the device answers at the fixed bus address; scl made by a divider
`include "sfs_regs.svh"

module sfs_host
  import sfs_pkg::*;
(
  // clock, reset, enable
  input wire logic CLOCK_IN,
  input wire logic RESET_N_IN,
  input wire logic CE_IN,
  // command port
  input wire logic CMD_VALID_IN,
  input wire logic CMD_READ_IN,
  input wire logic [7:0] CMD_REG_IN,
  input wire logic [7:0] CMD_WDATA_IN,
  output logic CMD_READY_OUT,
  output logic DONE_OUT,
  output logic [7:0] RDATA_OUT,
  output logic NACK_OUT,
  // bus
  sfs_i2c_if.host bus
);
  // =====================================================================
  // state
  sfs_host_e st_r; // sequencer phase
  logic [5:0] div_r; // quarter-bit divider
  logic [1:0] q_r; // quarter within a bit
  logic [3:0] bit_r; // bit in byte, 8 is the ack slot
  logic [1:0] byte_r; // byte in transfer
  logic rd_r; // read command
  sfs_byte_t reg_r; // register offset
  sfs_byte_t wd_r; // write data
  logic scl_drv_r; // pull scl low
  logic sda_drv_r; // pull sda low
  logic [1:0] sda_sy_r; // sda synchroniser
  wire sda_s = sda_sy_r[1];
  wire tick = div_r == 6'(`SFS_SCL_QDIV - 1);

  // =====================================================================
  // byte selection
  wire [7:0] byte_w = (byte_r == 2'h0) ? `SFS_ADDR_WR :
    (byte_r == 2'h1) ? reg_r : (byte_r == 2'h2) ? (rd_r ? `SFS_ADDR_RD : wd_r) : 8'hFF;
  wire [1:0] last_w = rd_r ? 2'h3 : 2'h2;
  // ack slots and read bits leave sda released; last read byte gets a nack
  wire tx_low = (bit_r < 4'h8) && !(rd_r && byte_r == 2'h3) &&
    !byte_w[3'(3'h7 - bit_r[2:0])];
  assign bus.host_scl_out = 1'b0;
  assign bus.host_scl_oe = scl_drv_r;
  assign bus.host_sda_out = 1'b0;
  assign bus.host_sda_oe = sda_drv_r;
  assign CMD_READY_OUT = st_r == HS_IDLE;

  // =====================================================================
  // sequencer: four quarters per bit, scl high in quarters 2 and 3
  always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      st_r <= HS_IDLE;
      div_r <= 6'h00;
      q_r <= 2'h0;
      bit_r <= 4'h0;
      byte_r <= 2'h0;
      rd_r <= 1'b0;
      reg_r <= 8'h00;
      wd_r <= 8'h00;
      scl_drv_r <= 1'b0;
      sda_drv_r <= 1'b0;
      sda_sy_r <= 2'h3;
      DONE_OUT <= 1'b0;
      RDATA_OUT <= 8'h00;
      NACK_OUT <= 1'b0;
    end else if (CE_IN) begin
      sda_sy_r <= {sda_sy_r[0], bus.sda};
      DONE_OUT <= 1'b0;
      div_r <= tick ? 6'h00 : div_r + 6'h01;
      if (st_r == HS_IDLE) begin
        // idle: both wires released
        scl_drv_r <= 1'b0;
        sda_drv_r <= 1'b0;
        div_r <= 6'h00;
        q_r <= 2'h0;
        if (CMD_VALID_IN) begin
          st_r <= HS_START;
          rd_r <= CMD_READ_IN;
          reg_r <= CMD_REG_IN;
          wd_r <= CMD_WDATA_IN;
          byte_r <= 2'h0;
          NACK_OUT <= 1'b0;
        end
      end else if (tick) begin
        q_r <= q_r + 2'h1;
        unique case (st_r)
          HS_START: begin
            // sda falls while scl high, then scl goes low
            if (q_r == 2'h0) sda_drv_r <= 1'b0;
            if (q_r == 2'h1) scl_drv_r <= 1'b0;
            if (q_r == 2'h2) sda_drv_r <= 1'b1;
            if (q_r == 2'h3) begin
              scl_drv_r <= 1'b1;
              st_r <= HS_BYTE;
              bit_r <= 4'h0;
            end
          end
          HS_BYTE: begin
            // sda moves only while scl is low
            if (q_r == 2'h0) sda_drv_r <= tx_low;
            if (q_r == 2'h1) scl_drv_r <= 1'b0;
            if (q_r == 2'h2) begin
              if (bit_r < 4'h8 && rd_r && byte_r == 2'h3) RDATA_OUT <= {RDATA_OUT[6:0], sda_s};
              if (bit_r == 4'h8 && byte_r != 2'h3 && sda_s) NACK_OUT <= 1'b1;
            end
            if (q_r == 2'h3) begin
              scl_drv_r <= 1'b1;
              bit_r <= bit_r + 4'h1;
              if (bit_r == 4'h8) begin
                bit_r <= 4'h0;
                byte_r <= byte_r + 2'h1;
                if (byte_r == last_w) st_r <= HS_STOP;
                else if (rd_r && byte_r == 2'h1) st_r <= HS_START;
              end
            end
          end
          HS_STOP: begin
            // sda rises while scl high
            if (q_r == 2'h0) sda_drv_r <= 1'b1;
            if (q_r == 2'h1) scl_drv_r <= 1'b0;
            if (q_r == 2'h2) sda_drv_r <= 1'b0;
            if (q_r == 2'h3) begin
              st_r <= HS_IDLE;
              DONE_OUT <= 1'b1;
            end
          end
          default: st_r <= HS_IDLE;
        endcase
      end
    end
  end
endmodule // sfs_host

// ===== testbench/sfs_props.sv
// checker: watches the two-wire bus between the host end and the device end
// assumes the bench instantiates it beside the bus interface, core clock samples the wires
module sfs_props (
  // clocks and reset
  input wire logic CLOCK_IN,
  input wire logic LINK_CLK_IN,
  input wire logic RESET_N_IN,
  // bus drives and resolved wires
  input wire logic host_scl_oe,
  input wire logic host_sda_oe,
  input wire logic dev_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge CLOCK_IN); endclocking
  default disable iff (!RESET_N_IN);
  // ======
  // frame tracking helpers
  logic scl_r, sda_r, busy_r, first_r, rd_r; // last wire levels, frame state
  logic [3:0] nbit_r; // bit position in the byte
  logic [7:0] sh_r; // bits of the current byte
  wire start_w = scl && scl_r && sda_r && !sda; // sda falls with scl high
  wire stop_w = scl && scl_r && !sda_r && sda; // sda rises with scl high
  wire rise_w = scl && !scl_r;
  wire ack_w = rise_w && nbit_r == 4'h8; // ninth clock of a byte
  // bit counting, restarted by any start so a repeated start realigns
  always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      {scl_r, sda_r, busy_r, first_r, rd_r} <= 5'h18;
      nbit_r <= 4'h0;
      sh_r <= 8'h00;
    end else begin
      scl_r <= scl;
      sda_r <= sda;
      if (start_w) begin
        {busy_r, first_r, rd_r} <= 3'h6;
        nbit_r <= 4'h0;
      end else if (stop_w) begin
        busy_r <= 1'b0;
      end else if (ack_w) begin
        first_r <= 1'b0;
        nbit_r <= 4'h0;
      end else if (rise_w) begin
        sh_r <= {sh_r[6:0], sda};
        nbit_r <= nbit_r + 4'h1;
        // direction bit is the eighth bit of the address byte
        if (first_r && nbit_r == 4'h7) begin
          rd_r <= sda;
        end
      end
    end
  end
  // ======
  // assertions
  addr_ack_a: assert property (ack_w && first_r && sh_r[7:1] == 7'h6B |-> !sda)
    else $error("own address byte not acknowledged");
  wr_ack_a: assert property (ack_w && !first_r && !rd_r |-> !sda)
    else $error("written byte not acknowledged");
  rd_nack_a: assert property (ack_w && !first_r && rd_r |-> sda && !dev_sda_oe)
    else $error("last read byte acknowledged");
  dev_steady_a: assert property (scl && $past(scl) |-> $stable(dev_sda_oe))
    else $error("device moved sda while scl high");
  dev_take_a: assert property (@(posedge LINK_CLK_IN) disable iff (!RESET_N_IN)
    $rose(dev_sda_oe) |-> !scl) else $error("device took sda with scl high");
  start_clk_a: assert property (start_w |-> ##[1:80] !scl)
    else $error("no clock after start");
  stop_free_a: assert property (stop_w |->
    (!host_scl_oe && !host_sda_oe && !dev_sda_oe) [*8]) else $error("bus held after stop");
  idle_high_a: assert property (!busy_r |-> scl && (sda || start_w))
    else $error("idle bus not released");
endmodule // sfs_props

// ===== testbench/system_fault_supervisor_bench.sv
// bench: host end and device end joined through the bus interface
// assumes short debounce counts; host commands are the access protocol
`include "sfs_regs.svh"
module system_fault_supervisor_bench
  import sfs_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  // ======
  // signals
  localparam int UV = 20, OV = 10, TS = 12, PU = 30; // shortened counts
  logic clk, lclk, rst_n, ce;
  logic c_valid, c_read, c_ready, c_done, c_nack;
  sfs_byte_t c_reg, c_wdata, c_rdata;
  logic uv, ov, bvdd, pwr, src, dot, cool, cot, mode; // comparator levels
  logic shdn, rrst, dshdn, pfault, pcur, coff;
  wire [3:0] mon = {pfault, dshdn, rrst, shdn}; // watched supervisor outputs
  int miscompares, compares;
  sfs_i2c_if bus ();
  sfs_host sfs_host_inst (.CLOCK_IN(clk), .RESET_N_IN(rst_n), .CE_IN(ce),
    .CMD_VALID_IN(c_valid), .CMD_READ_IN(c_read), .CMD_REG_IN(c_reg), .CMD_WDATA_IN(c_wdata),
    .CMD_READY_OUT(c_ready), .DONE_OUT(c_done), .RDATA_OUT(c_rdata), .NACK_OUT(c_nack),
    .bus(bus.host));
  sfs_device #(.UVLO_DEB_CYC(UV), .OVLO_DEB_CYC(OV), .DIE_OVERTEMP_SHUTDOWN_DEB_CYC(TS), .PWRUP_TMO_CYC(PU))
    sfs_device_inst (.CLOCK_IN(clk), .RESET_N_IN(rst_n), .CE_IN(ce), .LINK_CLK_IN(lclk),
    .RAIL_UNDERVOLT_IN(uv), .RAIL_OVERVOLT_IN(ov), .RAIL_BELOW_VDD_IN(bvdd),
    .RAIL_POWERED_IN(pwr), .SOURCE_VALID_IN(src), .DIE_OVERTEMP_IN(dot),
    .DIE_COOLED_IN(cool), .CHARGER_OVERTEMP_IN(cot), .CHG_OR_BUCK_MODE_IN(mode),
    .SHUTDOWN_OUT(shdn), .REG_RESET_OUT(rrst), .DIE_OVERTEMP_SHUTDOWN_OUT(dshdn),
    .POWERUP_FAULT_OUT(pfault), .POWERUP_CURRENT_EN_OUT(pcur), .CHARGER_OFF_OUT(coff),
    .bus(bus.dev));
  sfs_props sfs_props_inst (.CLOCK_IN(clk), .LINK_CLK_IN(lclk), .RESET_N_IN(rst_n),
    .host_scl_oe(bus.host_scl_oe), .host_sda_oe(bus.host_sda_oe),
    .dev_sda_oe(bus.dev_sda_oe), .scl(bus.scl), .sda(bus.sda));
  // ======
  // clocks, link clock offset so the phases never line up
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    lclk = 1'b0;
    #3;
    forever #24 lclk = ~lclk;
  end
  // ======
  // tasks
  task automatic conclude();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one host command, held until the edge that takes it, done awaited under a bound
  task automatic xfer(input logic rd, input sfs_byte_t r, input sfs_byte_t w,
    input sfs_byte_t exp);
    int n;
    n = 0;
    {c_valid, c_read, c_reg, c_wdata} = {1'b1, rd, r, w};
    @(negedge clk);
    c_valid = 1'b0;
    check("ready while busy", 8'h00, {7'h00, c_ready});
    while (c_done !== 1'b1 && n < 6000) begin
      @(negedge clk);
      n++;
    end
    if (n >= 6000) begin
      miscompares++;
      conclude();
    end
    check("nack", 8'h00, {7'h00, c_nack});
    if (rd) check("read data", exp, c_rdata);
    @(negedge clk);
  endtask
  // waits for a watched output to reach a level, the delay must fall in a window
  task automatic wait_bit(input int b, input logic v, input int lo, input int hi,
    input string what);
    int n;
    n = 0;
    while (mon[b] !== v && n < hi) begin
      @(negedge clk);
      n++;
    end
    compares++;
    if (n < lo || n >= hi) begin
      miscompares++;
      $display("wrong value %s expected %0d to %0d seen %0d", what, lo, hi, n);
      if (mon[b] !== v) conclude();
    end
  endtask
  // ======
  // main sequence
  initial begin
    {ce, c_valid, c_read, c_reg, c_wdata} = {1'b1, 1'b0, 1'b0, 8'h00, 8'h00};
    {uv, ov, bvdd, pwr, src, dot, cool, cot, mode} = 9'h025;
    {miscompares, compares} = {32'h0, 32'h0};
    rst_n = 1'b0;
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    check("outputs after reset", 8'h00, {4'h0, mon});
    xfer(1, `SFS_REG_ID, 8'h00, `SFS_CHIP_ID);
    xfer(1, `SFS_REG_CTRL, 8'h00, 8'h00);
    xfer(1, 8'h40, 8'h00, 8'h00);
    xfer(0, `SFS_REG_CTRL, 8'h01, 8'h00);
    xfer(1, `SFS_REG_CTRL, 8'h00, 8'h01);
    // undervolt shorter than the debounce must not trip
    uv = 1'b1;
    repeat (UV - 4) @(negedge clk);
    uv = 1'b0;
    repeat (10) @(negedge clk);
    check("short undervolt", 8'h00, {4'h0, mon});
    uv = 1'b1;
    wait_bit(0, 1, UV, UV + 10, "undervolt trip");
    check("undervolt reset", 8'h01, {7'h00, rrst});
    // hold the fault long enough for the link side to see the reset
    repeat (40) @(negedge clk);
    uv = 1'b0;
    xfer(1, `SFS_REG_CTRL, 8'h00, 8'h00);
    xfer(1, `SFS_REG_INT, 8'h00, 8'h10);
    xfer(1, `SFS_REG_INT, 8'h00, 8'h00);
    // overvolt debounced, then direct once the trip cleared the enable
    xfer(0, `SFS_REG_CTRL, 8'h01, 8'h00);
    ov = 1'b1;
    wait_bit(0, 1, OV, OV + 10, "overvolt debounced");
    repeat (40) @(negedge clk);
    ov = 1'b0;
    wait_bit(0, 0, 0, 20, "overvolt release");
    repeat (40) @(negedge clk);
    ov = 1'b1;
    wait_bit(0, 1, 1, 10, "overvolt direct");
    ov = 1'b0;
    xfer(1, `SFS_REG_INT, 8'h00, 8'h20);
    // die overtemperature with hysteresis
    cool = 1'b0;
    dot = 1'b1;
    wait_bit(2, 1, TS, TS + 10, "die shutdown");
    check("die shutdown acts", 8'h03, {6'h00, rrst, shdn});
    dot = 1'b0;
    repeat (20) @(negedge clk);
    check("die hysteresis", 8'h01, {7'h00, dshdn});
    cool = 1'b1;
    wait_bit(2, 0, 0, 10, "die cooled");
    xfer(1, `SFS_REG_INT, 8'h00, 8'h40);
    // charger overheating touches only the charger
    cot = 1'b1;
    repeat (10) @(negedge clk);
    check("charger only", 8'h10, {3'h0, coff, mon});
    cot = 1'b0;
    // outside charge or buck mode the debounce is bypassed
    mode = 1'b0;
    uv = 1'b1;
    wait_bit(0, 1, 1, 10, "bypassed debounce");
    {uv, mode} = 2'h1;
    wait_bit(0, 0, 0, 20, "undervolt release");
    // powerup timeout, second pass cleared by the supply-loss reset
    for (int p = 0; p < 2; p++) begin
      {pwr, src} = 2'h1;
      repeat (8) @(negedge clk);
      check("powerup current", 8'h01, {7'h00, pcur});
      wait_bit(3, 1, PU - 8, PU + 10, "powerup fault");
      {pwr, src} = 2'h2;
      wait_bit(3, 0, 0, 10, "fault release");
      if (p == 1) begin
        bvdd = 1'b1;
        wait_bit(1, 1, 0, 10, "supply reset");
        repeat (40) @(negedge clk);
        bvdd = 1'b0;
      end
      xfer(1, `SFS_REG_INT, 8'h00, p == 0 ? 8'h11 : 8'h00);
    end
    conclude();
  end
endmodule // system_fault_supervisor_bench
